// ### design/flags_regs.svh
/*
  Bit positions, field codes and reset values for the condition and
  floating-point status flag block.
  Assumes big-endian bit numbering: bit n of a 32-bit register is
  vector index 31-n.
*/
`ifndef FLAGS_REGS_SVH
`define FLAGS_REGS_SVH

// control fields of the fp status/control register, big-endian bit numbers
`define UE_BIT 26
`define ZE_BIT 27
`define XE_BIT 28
`define NI_BIT 29
`define RN_HI_BIT 30
`define RN_LO_BIT 31

// bits of the fp status/control register kept inside this block
`define OWN_MASK 32'h0001F03F

// rounding control encodings
`define RN_NEAREST 2'h0
`define RN_PLUS_INF 2'h1
`define RN_ZERO 2'h2
`define RN_MINUS_INF 2'h3

// result class flags, {class, less, greater, equal, unordered}
`define CLS_QNAN 5'h11
`define CLS_MINF 5'h09
`define CLS_MNORM 5'h08
`define CLS_MDEN 5'h18
`define CLS_MZERO 5'h12
`define CLS_PZERO 5'h02
`define CLS_PDEN 5'h14
`define CLS_PNORM 5'h04
`define CLS_PINF 5'h05

// reset values
`define CR_RESET 32'h00000000
`define FPO_RESET 32'h00000000

`endif

// ### design/flags_pkg.sv
/*
  Types shared by the condition and fp status flag block.
  Assumes the decoder presents one condition register operation per
  cycle, with immediates already extended to 32 bits.
*/
package flags_pkg;

  typedef enum logic [3:0] {
    OP_NONE, OP_MTCRF, OP_MCRF, OP_MCRXR, OP_MCRFS, OP_CRLOG,
    OP_INT_RES, OP_FP_RES, OP_CMP_S, OP_CMP_U, OP_CMP_FP
  } cr_op_t;

  typedef enum logic [2:0] {
    LOG_AND, LOG_OR, LOG_XOR, LOG_NAND, LOG_NOR, LOG_EQV, LOG_ANDC,
    LOG_ORC
  } crlog_t;

  typedef enum logic [1:0] {
    REL_LT, REL_GT, REL_EQ, REL_UN
  } fp_rel_t;

  typedef enum logic [3:0] {
    CL_QNAN, CL_MINF, CL_MNORM, CL_MDEN, CL_MZERO, CL_PZERO, CL_PDEN,
    CL_PNORM, CL_PINF
  } fp_class_t;

  typedef enum logic [1:0] {
    RND_NEAREST, RND_PLUS_INF, RND_ZERO, RND_MINUS_INF
  } rnd_t;

  typedef struct packed {
    cr_op_t op;
    logic [2:0] dst_field;
    logic [2:0] src_field;
    logic [7:0] field_mask;
    crlog_t func;
    logic [4:0] bit_t;
    logic [4:0] bit_a;
    logic [4:0] bit_b;
    logic [31:0] opa;
    logic [31:0] opb;
    fp_rel_t fp_rel;
  } cr_req_t;

  typedef struct packed {
    logic [31:0] integer_exception_reg;
    logic [31:0] fp_status_control_rest;
  } core_status_t;

  typedef struct packed {
    logic en;
    logic [7:0] field_mask;
    logic [31:0] data;
  } ctl_wr_t;

  typedef struct packed {
    logic valid;
    fp_class_t cls;
  } fp_class_in_t;

  typedef struct packed {
    logic underflow_enable;
    logic zero_divide_enable;
    logic inexact_enable;
    logic denormal_flush_mode;
    rnd_t rounding_control;
  } fp_ctl_t;

  typedef struct packed {
    logic [31:0] cr;
    logic [31:0] fpo;
    logic flush;
  } state_t;

endpackage

// ### design/cond_fp_flags.sv
/*
  Condition register and the owned fields of the fp status/control
  register: exception enables, flush mode, rounding control and the
  result class flags.
  Assumes execution units and decoder drive at most one operation per
  cycle, synchronous to clk_sys, and supply the other fp status bits.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flags_regs.svh"

module cond_fp_flags (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // decoder and execution units
  input wire flags_pkg::cr_req_t req,
  input wire flags_pkg::core_status_t stat,
  input wire flags_pkg::ctl_wr_t ctl_wr,
  input wire flags_pkg::fp_class_in_t fcls,
  // register views and controls
  output logic [31:0] condition_flags_reg,
  output logic [31:0] fp_status_control_reg,
  output var flags_pkg::fp_ctl_t fp_ctl,
  output logic flush_zero_pulse
);
  import flags_pkg::*;

  // owned-bit mask as a vector, so single bits can be selected
  localparam logic [31:0] own_mask = `OWN_MASK;

  state_t s_r;
  state_t s_nxt;
  logic [31:0] fpv;
  logic [31:0] mt_val;
  logic [4:0] cls_code;
  logic cls_flushed;

  // field k sits at index (7-k)*4, bit 0 of a field is its msb
  function automatic logic [3:0] get_fld(input logic [31:0] v,
                                         input logic [2:0] k);
    get_fld = v[{~k, 2'b00} +: 4];
  endfunction

  function automatic logic [31:0] put_fld(input logic [31:0] v,
                                          input logic [2:0] k,
                                          input logic [3:0] d);
    logic [31:0] r;
    r = v;
    r[{~k, 2'b00} +: 4] = d;
    put_fld = r;
  endfunction

  function automatic logic do_log(input crlog_t f, input logic a,
                                  input logic b);
    case (f)
      LOG_AND: do_log = a & b;
      LOG_OR: do_log = a | b;
      LOG_XOR: do_log = a ^ b;
      LOG_NAND: do_log = ~(a & b);
      LOG_NOR: do_log = ~(a | b);
      LOG_EQV: do_log = ~(a ^ b);
      LOG_ANDC: do_log = a & ~b;
      default: do_log = a | ~b;
    endcase
  endfunction

  // full fp status/control view: owned bits over the rest
  assign fpv = (stat.fp_status_control_rest & ~`OWN_MASK) | s_r.fpo;

  // move from general register, field by field under the mask
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_mt
      assign mt_val[(7 - g) * 4 +: 4] = req.field_mask[7 - g] ?
        req.opa[(7 - g) * 4 +: 4] : s_r.cr[(7 - g) * 4 +: 4];
    end
  endgenerate

  // class code, with denormals flushed to signed zero in flush mode
  always_comb begin
    cls_flushed = 1'b0;
    case (fcls.cls)
      CL_QNAN: cls_code = `CLS_QNAN;
      CL_MINF: cls_code = `CLS_MINF;
      CL_PINF: cls_code = `CLS_PINF;
      CL_MNORM: cls_code = `CLS_MNORM;
      CL_PNORM: cls_code = `CLS_PNORM;
      CL_MZERO: cls_code = `CLS_MZERO;
      CL_PZERO: cls_code = `CLS_PZERO;
      CL_MDEN: begin
        cls_flushed = fp_ctl.denormal_flush_mode;
        cls_code = cls_flushed ? `CLS_MZERO : `CLS_MDEN;
      end
      CL_PDEN: begin
        cls_flushed = fp_ctl.denormal_flush_mode;
        cls_code = cls_flushed ? `CLS_PZERO : `CLS_PDEN;
      end
      default: cls_code = `CLS_QNAN;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.flush = 1'b0;
    // result class from arithmetic, rounding and conversion
    if (fcls.valid) begin
      s_nxt.fpo[16:12] = cls_code;
      s_nxt.flush = cls_flushed;
    end
    // software writes to owned bits; a write overrides a class update
    if (ctl_wr.en) begin
      for (int n = 0; n < 32; n++) begin
        if (own_mask[31 - n] && ctl_wr.field_mask[7 - n / 4]) begin
          s_nxt.fpo[31 - n] = ctl_wr.data[31 - n];
        end
      end
    end
    case (req.op)
      OP_MTCRF: s_nxt.cr = mt_val;
      OP_MCRF: s_nxt.cr = put_fld(s_r.cr, req.dst_field,
        get_fld(s_r.cr, req.src_field));
      OP_MCRXR: s_nxt.cr = put_fld(s_r.cr, req.dst_field,
        stat.integer_exception_reg[31:28]);
      OP_MCRFS: s_nxt.cr = put_fld(s_r.cr, req.dst_field,
        get_fld(fpv, req.src_field));
      OP_CRLOG: s_nxt.cr[~req.bit_t] = do_log(req.func,
        s_r.cr[~req.bit_a], s_r.cr[~req.bit_b]);
      OP_INT_RES: s_nxt.cr = put_fld(s_r.cr, 3'h0, {
        req.opa[31],
        ~req.opa[31] && (req.opa != 32'h00000000),
        req.opa == 32'h00000000,
        stat.integer_exception_reg[31]});
      OP_FP_RES: s_nxt.cr = put_fld(s_r.cr, 3'h1,
        fpv[31:28]);
      OP_CMP_S: s_nxt.cr = put_fld(s_r.cr, req.dst_field, {
        $signed(req.opa) < $signed(req.opb),
        $signed(req.opa) > $signed(req.opb),
        req.opa == req.opb,
        stat.integer_exception_reg[31]});
      OP_CMP_U: s_nxt.cr = put_fld(s_r.cr, req.dst_field, {
        req.opa < req.opb,
        req.opa > req.opb,
        req.opa == req.opb,
        stat.integer_exception_reg[31]});
      OP_CMP_FP: begin
        s_nxt.cr = put_fld(s_r.cr, req.dst_field, {
          req.fp_rel == REL_LT,
          req.fp_rel == REL_GT,
          req.fp_rel == REL_EQ,
          req.fp_rel == REL_UN});
        // compare outcome also lands in the fp condition code bits
        s_nxt.fpo[15:12] = get_fld(s_nxt.cr, req.dst_field);
      end
      default: s_nxt.cr = s_r.cr;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r.cr <= `CR_RESET;
      s_r.fpo <= `FPO_RESET;
      s_r.flush <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign condition_flags_reg = s_r.cr;
  assign fp_status_control_reg = fpv;
  assign flush_zero_pulse = s_r.flush;
  always_comb begin
    fp_ctl.underflow_enable = s_r.fpo[31 - `UE_BIT];
    fp_ctl.zero_divide_enable = s_r.fpo[31 - `ZE_BIT];
    fp_ctl.inexact_enable = s_r.fpo[31 - `XE_BIT];
    fp_ctl.denormal_flush_mode = s_r.fpo[31 - `NI_BIT];
    case ({s_r.fpo[31 - `RN_HI_BIT], s_r.fpo[31 - `RN_LO_BIT]})
      `RN_NEAREST: fp_ctl.rounding_control = RND_NEAREST;
      `RN_PLUS_INF: fp_ctl.rounding_control = RND_PLUS_INF;
      `RN_ZERO: fp_ctl.rounding_control = RND_ZERO;
      default: fp_ctl.rounding_control = RND_MINUS_INF;
    endcase
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_ctl_hold;
    !ctl_wr.en |=> $stable(s_r.fpo[5:0]);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("control bits changed without a write");

  property p_ctl_write;
    ctl_wr.en && ctl_wr.field_mask[1] |=>
      fp_ctl.underflow_enable == $past(ctl_wr.data[5]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("underflow enable not written");

  property p_flush;
    fcls.valid && fcls.cls == CL_PDEN && fp_ctl.denormal_flush_mode &&
      !ctl_wr.en && req.op != OP_CMP_FP |=>
      s_r.fpo[16:12] == `CLS_PZERO && flush_zero_pulse;
  endproperty
  a_flush: assert property (p_flush)
    else $error("denormal not flushed to zero");

  property p_flush_pulse_idle;
    !fcls.valid |=> !flush_zero_pulse;
  endproperty
  a_flush_pulse_idle: assert property (p_flush_pulse_idle)
    else $error("flush pulse without a class result");

  property p_rnd;
    s_r.fpo[1:0] == 2'h1 |-> fp_ctl.rounding_control == RND_PLUS_INF;
  endproperty
  a_rnd: assert property (p_rnd)
    else $error("rounding decode wrong");

  property p_qnan;
    fcls.valid && fcls.cls == CL_QNAN && !ctl_wr.en &&
      req.op != OP_CMP_FP |=> s_r.fpo[16:12] == 5'h11;
  endproperty
  a_qnan: assert property (p_qnan)
    else $error("quiet nan class code wrong");

  property p_fcmp_onehot;
    req.op == OP_CMP_FP |=> $onehot(s_r.fpo[15:12]);
  endproperty
  a_fcmp_onehot: assert property (p_fcmp_onehot)
    else $error("fp compare code not one-hot");

  property p_fcmp_un;
    req.op == OP_CMP_FP && req.fp_rel == REL_UN |=>
      get_fld(s_r.cr, $past(req.dst_field)) == 4'h1;
  endproperty
  a_fcmp_un: assert property (p_fcmp_un)
    else $error("unordered compare wrong");

  property p_mcrxr;
    req.op == OP_MCRXR |=> get_fld(s_r.cr, $past(req.dst_field)) ==
      $past(stat.integer_exception_reg[31:28]);
  endproperty
  a_mcrxr: assert property (p_mcrxr)
    else $error("exception field copy wrong");

  property p_mcrf;
    req.op == OP_MCRF |=> get_fld(s_r.cr, $past(req.dst_field)) ==
      get_fld($past(s_r.cr), $past(req.src_field));
  endproperty
  a_mcrf: assert property (p_mcrf)
    else $error("field copy wrong");

  property p_crlog_and;
    req.op == OP_CRLOG && req.func == LOG_AND |=>
      s_r.cr[~$past(req.bit_t)] ==
      ($past(s_r.cr[~req.bit_a]) & $past(s_r.cr[~req.bit_b]));
  endproperty
  a_crlog_and: assert property (p_crlog_and)
    else $error("condition bit and wrong");

  property p_int_zero;
    req.op == OP_INT_RES && req.opa == 32'h00000000 |=>
      s_r.cr[31:29] == 3'h1 && s_r.cr[28] ==
      $past(stat.integer_exception_reg[31]);
  endproperty
  a_int_zero: assert property (p_int_zero)
    else $error("field zero wrong for zero result");

  property p_fp_res;
    req.op == OP_FP_RES |=> s_r.cr[27:24] == $past(fpv[31:28]);
  endproperty
  a_fp_res: assert property (p_fp_res)
    else $error("field one summary copy wrong");

  property p_cmp_u_lt;
    req.op == OP_CMP_U && req.opa < req.opb |=>
      get_fld(s_r.cr, $past(req.dst_field)) ==
      {3'h4, $past(stat.integer_exception_reg[31])};
  endproperty
  a_cmp_u_lt: assert property (p_cmp_u_lt)
    else $error("unsigned less compare wrong");

  property p_cmp_s_gt;
    req.op == OP_CMP_S && $signed(req.opa) > $signed(req.opb) |=>
      get_fld(s_r.cr, $past(req.dst_field)) ==
      {3'h2, $past(stat.integer_exception_reg[31])};
  endproperty
  a_cmp_s_gt: assert property (p_cmp_s_gt)
    else $error("signed greater compare wrong");

  property p_cmp_eq;
    req.op == OP_CMP_U && req.opa == req.opb |=>
      get_fld(s_r.cr, $past(req.dst_field)) ==
      {3'h1, $past(stat.integer_exception_reg[31])};
  endproperty
  a_cmp_eq: assert property (p_cmp_eq)
    else $error("equal compare wrong");

endmodule

`default_nettype wire

// ### verification/core_side.sv
/*
  Core-side driver: decoder and execution units feeding the flag block
  one operation, status image, control write and class event a cycle.
  Assumes the bench calls issue just after a falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module core_side (
  // towards the flag block
  output var flags_pkg::cr_req_t req,
  output var flags_pkg::core_status_t stat,
  output var flags_pkg::ctl_wr_t ctl_wr,
  output var flags_pkg::fp_class_in_t fcls
);
  import flags_pkg::*;

  initial begin
    req = '0;
    stat = '0;
    ctl_wr = '0;
    fcls = '0;
  end

  // all signals of one cycle change together and hold to the next call
  task automatic issue(input cr_req_t r, input core_status_t s,
                       input ctl_wr_t w, input fp_class_in_t f);
    req = r;
    stat = s;
    ctl_wr = w;
    fcls = f;
  endtask

endmodule

`default_nettype wire

// ### verification/tb_condition_and_fp_status_flags.sv
/*
  Self-checking bench for the condition and fp status flag block.
  Assumes the design header and package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_condition_and_fp_status_flags;
  import flags_pkg::*;
  logic clk_sys;
  logic reset_n;
  cr_req_t req;
  core_status_t stat;
  ctl_wr_t ctl_wr;
  fp_class_in_t fcls;
  logic [31:0] cr_out;
  logic [31:0] fps_out;
  fp_ctl_t ctl_out;
  logic pulse;
  logic [31:0] cr_m;
  logic [31:0] fpo_m;
  logic pulse_m;
  logic [31:0] lfsr;
  int bad_count;
  int num_checks;
  // class codes {class, less, greater, equal, unordered} in enum order
  logic [4:0] cls_tab [9] = '{5'h11, 5'h09, 5'h08, 5'h18, 5'h12, 5'h02,
                              5'h14, 5'h04, 5'h05};
  // truth tables indexed by {a, b}
  logic [3:0] log_tab [8] = '{4'h8, 4'hE, 4'h6, 4'h7, 4'h1, 4'h9, 4'h4,
                              4'hD};

  core_side u_core (.req(req), .stat(stat), .ctl_wr(ctl_wr), .fcls(fcls));

  cond_fp_flags dut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
    .stat(stat), .ctl_wr(ctl_wr), .fcls(fcls),
    .condition_flags_reg(cr_out), .fp_status_control_reg(fps_out),
    .fp_ctl(ctl_out), .flush_zero_pulse(pulse));

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [31:0] expand(input logic [7:0] m);
    logic [31:0] e;
    for (int j = 0; j < 8; j++) e[j*4 +: 4] = {4{m[j]}};
    return e;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic model(input cr_req_t r, input core_status_t s,
                       input ctl_wr_t w, input fp_class_in_t f);
    logic [3:0] nb;
    logic [31:0] v;
    logic [31:0] em;
    logic [2:0] d;
    logic wr;
    logic so;
    so = s.integer_exception_reg[31];
    v = fpo_m | s.fp_status_control_rest;
    d = r.dst_field;
    wr = 1'b1;
    nb = 4'h0;
    pulse_m = 1'b0;
    if (f.valid) begin
      fpo_m[16:12] = cls_tab[f.cls];
      if (fpo_m[2] && (f.cls == CL_MDEN || f.cls == CL_PDEN)) begin
        fpo_m[16:12] = (f.cls == CL_MDEN) ? 5'h12 : 5'h02;
        pulse_m = 1'b1;
      end
    end
    em = expand(w.field_mask) & 32'h0001F03F;
    if (w.en) fpo_m = (fpo_m & ~em) | (w.data & em);
    em = expand(r.field_mask);
    case (r.op)
      OP_MTCRF: cr_m = (cr_m & ~em) | (r.opa & em);
      OP_MCRF: nb = cr_m[(7 - r.src_field)*4 +: 4];
      OP_MCRXR: nb = s.integer_exception_reg[31:28];
      OP_MCRFS: nb = v[(7 - r.src_field)*4 +: 4];
      OP_CRLOG: cr_m[31 - r.bit_t] =
        log_tab[r.func][{cr_m[31 - r.bit_a], cr_m[31 - r.bit_b]}];
      OP_INT_RES: begin
        nb = {r.opa[31], !r.opa[31] && r.opa != 0, r.opa == 0, so};
        d = 3'h0;
      end
      OP_FP_RES: begin
        nb = s.fp_status_control_rest[31:28];
        d = 3'h1;
      end
      OP_CMP_S: nb = {$signed(r.opa) < $signed(r.opb),
                      $signed(r.opa) > $signed(r.opb), r.opa == r.opb, so};
      OP_CMP_U: nb = {r.opa < r.opb, r.opa > r.opb, r.opa == r.opb, so};
      OP_CMP_FP: begin
        nb = 4'h8 >> r.fp_rel;
        fpo_m[15:12] = nb;
      end
      default: wr = 1'b0;
    endcase
    if (wr && r.op != OP_MTCRF && r.op != OP_CRLOG) cr_m[(7-d)*4 +: 4] = nb;
  endtask

  task automatic cyc(input cr_req_t r, input core_status_t s,
                     input ctl_wr_t w, input fp_class_in_t f);
    u_core.issue(r, s, w, f);
    model(r, s, w, f);
    @(negedge clk_sys);
    chk("condition_flags_reg", cr_m, cr_out);
    chk("fp_status_control_reg", fpo_m | s.fp_status_control_rest, fps_out);
    chk("fp_ctl", {26'h0, fpo_m[5:0]}, 32'(ctl_out));
    chk("flush_zero_pulse", 32'(pulse_m), 32'(pulse));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  initial begin
    cr_req_t r;
    core_status_t s;
    ctl_wr_t w;
    fp_class_in_t f;
    logic [127:0] raw;
    bad_count = 0;
    num_checks = 0;
    lfsr = 32'h00004D11;
    reset_n = 1'b0;
    cr_m = '0;
    fpo_m = '0;
    s = '0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    cyc('0, s, '0, '0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      s.fp_status_control_rest = rnd() & 32'hFFFE0FC0;
      w.en = 1'b1;
      w.field_mask = 8'(rnd()) | 8'h01;
      w.data = rnd();
      w.data[1:0] = 2'(i);
      cyc('0, s, w, '0);
    end
    $display("test control writes done");
    for (int n = 0; n < 2; n++) begin
      w = '0;
      w.en = 1'b1;
      w.field_mask = 8'h01;
      w.data = 32'(n) << 2;
      cyc('0, s, w, '0);
      for (int c = 0; c < 9; c++) begin
        f.valid = 1'b1;
        f.cls = fp_class_t'(4'(c));
        cyc('0, s, '0, f);
      end
      cyc('0, s, '0, '0);
    end
    $display("test result classes done");
    for (int i = 0; i < 600; i++) begin
      raw = {rnd(), rnd(), rnd(), rnd()};
      r = raw[$bits(cr_req_t)-1:0];
      r.op = cr_op_t'(4'(1 + rnd() % 10));
      if (lfsr[7:5] == 3'h0) r.opa = '0;
      if (lfsr[3]) r.opb = r.opa;
      s.integer_exception_reg = rnd();
      s.fp_status_control_rest = rnd() & 32'hFFFE0FC0;
      cyc(r, s, '0, '0);
    end
    $display("test condition operations done");
    reset_n = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
    cr_m = '0;
    fpo_m = '0;
    cyc('0, s, '0, '0);
    $display("test second reset done");
    give_verdict();
  end

endmodule

`default_nettype wire
